// >>> rtl/adcrz_map.svh
// constants for the adc mode, rms and crossing control block
// assumes a 100 MHz clock; register offsets are word indices, byte address is four times the index
// What this block does
// - Host sets rms source channel and window count, then sets rms run enable.
// - Rms waits for the window of samples, then 40 more conversions.
// - On rms completion set complete flag; alert pin asserts when alert mapping set.
// - Each write of 1 to rms run enable starts a fresh measurement.
// - Crossing detector watches the 4-bit source channel against upper threshold.
// - Each unblanked crossing-channel result compared with threshold drives detector high or low.
// - Detector output routed to outputs by update enables and per-output value fields.
// - Blanking lasts multiplier enable times blanking count crossing-channel samples.
// - Minimum, maximum and latest code kept per channel while recording is enabled.
// - Writing 1 to record enable restarts statistics; old values stay readable.
// - Device acknowledges a general-call address byte 00h.
// - General call then 06h resets the whole device.
// - General call then 04h re-reads address pin; only general calls answered meanwhile.
// - Codes 09h, 0bh, 0dh, 0fh set high-speed status until a stop.
// - Mode from conversion and sequence fields: 00/00 manual, 00/01 auto, 01/01 autonomous.
// - Manual mode channel from manual select field, started on link acknowledge edge.
// - Device comes up in manual mode until reconfigured.
// - At power-up address taken from address pin and brownout flag set.
// - Reset by general-call reset byte, software reset bit, or supply cycling.
// - Manual conversion starts on ninth falling edge after last data byte read.
// - Sequencer steps to next enabled channel ascending; sequencer run starts or stops it.
`ifndef ADCRZ_MAP_SVH
`define ADCRZ_MAP_SVH
`define ADCRZ_REG_STATUS 4'h0
`define ADCRZ_REG_GCFG 4'h1
`define ADCRZ_REG_CHAN 4'h2
`define ADCRZ_REG_ZCFG 4'h3
`define ADCRZ_REG_GPO 4'h4
`define ADCRZ_REG_RMS 4'h5
`define ADCRZ_REG_SSEL 4'h6
`define ADCRZ_REG_SMM 4'h7
`define ADCRZ_REG_SLAT 4'h8
`define ADCRZ_THRESH_RST 12'hfff
`define ADCRZ_ADDR_BASE 7'h10
`define ADCRZ_GC_ADDR 8'h00
`define ADCRZ_GC_RESET 8'h06
`define ADCRZ_GC_REEVAL 8'h04
`define ADCRZ_HS_MASK 8'hf9
`define ADCRZ_HS_CODE 8'h09
`define ADCRZ_CM_MANUAL 2'h0
`define ADCRZ_CM_AUTON 2'h1
`define ADCRZ_SM_MANUAL 2'h0
`define ADCRZ_SM_SEQ 2'h1
`define ADCRZ_ZV_LOW 2'h0
`define ADCRZ_ZV_HIGH 2'h1
`define ADCRZ_ZV_ZCD 2'h2
`define ADCRZ_RMS_TAIL 6'h28
`define ADCRZ_WIN_SHIFT_BASE 5'h0a
`define ADCRZ_CLK_NS 10
`define ADCRZ_AUTON_NS 1000
`define ADCRZ_AUTON_CYC (`ADCRZ_AUTON_NS / `ADCRZ_CLK_NS)
`define ADCRZ_EVAL_NS 100
`define ADCRZ_EVAL_CYC (`ADCRZ_EVAL_NS / `ADCRZ_CLK_NS)
`define ADCRZ_BIT_LAST 4'h8
`endif

// >>> rtl/adcrz_pkg.sv
// types for the adc mode, rms and crossing control block
// assumes adcrz_map.svh supplies the constants
package adcrz_pkg;
  typedef enum logic [2:0] {
    I_IDLE = 3'b000, I_ADDR = 3'b001, I_AACK = 3'b010, I_WR = 3'b011,
    I_WACK = 3'b100, I_RD = 3'b101, I_RACK = 3'b110
  } adcrz_i2c_t;
  typedef enum logic [1:0] {
    R_IDLE = 2'b00, R_ACC = 2'b01, R_SQRT = 2'b10, R_TAIL = 2'b11
  } adcrz_rms_t;
  typedef enum logic [1:0] {
    M_MANUAL = 2'b00, M_AUTO = 2'b01, M_AUTON = 2'b10, M_NONE = 2'b11
  } adcrz_mode_t;
  typedef struct packed {
    logic [2:0] ch;
    logic [11:0] data;
  } adcrz_conv_t;
  typedef struct packed {
    logic [23:0] rsv;
    logic [1:0] sequence_mode_field;
    logic [1:0] conversion_mode;
    logic sequencer_run;
    logic soft_reset;
    logic statistics_record_enable;
    logic rms_run_enable;
  } adcrz_gcfg_t;
  typedef struct packed {
    logic [7:0] rsv;
    logic [7:0] sequencer_channel_mask;
    logic [1:0] rsv1;
    logic [1:0] rms_window_count;
    logic [3:0] rms_source_channel;
    logic [3:0] crossing_source_channel;
    logic rsv0;
    logic [2:0] manual_channel_select;
  } adcrz_chan_t;
  typedef struct packed {
    logic [6:0] rsv;
    logic rms_alert_mapping;
    logic blanking_multiplier_enable;
    logic [6:0] crossing_blanking_count;
    logic [3:0] rsv1;
    logic [11:0] upper_threshold;
  } adcrz_zcfg_t;
  typedef struct packed {
    logic [7:0] rsv;
    logic [3:0][1:0] crossing_value_cfg_high_outputs;
    logic [3:0][1:0] crossing_value_cfg_low_outputs;
    logic [7:0] output_crossing_update_enable;
  } adcrz_gpo_t;
  typedef struct packed {
    logic [1:0] scl_sy, sda_sy;
    logic scl_d, sda_d;
    logic [2:0] addr_sy1, addr_sy2;
    adcrz_i2c_t i2c;
    logic [3:0] bitn;
    logic [7:0] shreg, txb;
    logic rd, gc, txsel, sda_low;
    logic [6:0] dev_addr;
    logic [3:0] eval_cnt;
    logic eval_busy, soft_rst, hs, bor, rms_complete_flag;
    adcrz_gcfg_t gcfg;
    adcrz_chan_t chan;
    adcrz_zcfg_t zcfg;
    adcrz_gpo_t gpo;
    logic [2:0] stat_sel;
    logic [7:0][11:0] stat_min, stat_max, stat_lat;
    logic [7:0] stat_valid;
    logic srv;
    logic [31:0] rdata;
    logic conv_go, busy, auton_run;
    logic [2:0] conv_ch;
    logic [11:0] last_data, tmr;
    logic zero_crossing_detector;
    logic [6:0] blank_cnt;
    logic [7:0] gpo_q;
    adcrz_rms_t rms_st;
    logic [40:0] sumsq;
    logic [16:0] nsamp;
    logic [5:0] tail;
    logic [31:0] rad;
    logic [15:0] root, rms_res;
    logic [3:0] sq_i;
  } adcrz_state_t;
endpackage

// >>> rtl/adcrz_control.sv
// adc conversion mode, rms, crossing, statistics and serial link control
// assumes conversions are done by an adc on the same clock; link pins are asynchronous
`timescale 1ns/100ps
`default_nettype none
`include "adcrz_map.svh"
module adcrz_control import adcrz_pkg::*; (
  input wire logic clk_i, // 100 MHz clock
  input wire logic reset_i, // synchronous reset, high
  input wire logic ce_i, // clock enable
  input wire logic [3:0] avs_address_i, // word index
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [31:0] avs_writedata_i, // write data
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall
  input wire logic scl_i, // link clock pin
  input wire logic sda_i, // link data pin in
  output logic sda_o, // link data out, always low
  output logic sda_oe_o, // high while pulling data low
  input wire logic [2:0] addr_pin_i, // address strap level
  output logic conv_start_o, // one-cycle conversion start
  output logic [2:0] conv_channel_o, // multiplexer channel
  input wire logic conv_done_i, // conversion result valid
  input wire adcrz_conv_t conv_i, // conversion result
  output logic alert_o, // alert request, high
  output logic [7:0] gpo_o, // digital outputs
  output logic [6:0] dev_addr_o, // current bus address
  output logic high_speed_o // high-speed link mode
);
  adcrz_state_t s, next_s;

  function automatic adcrz_state_t reset_state();
    adcrz_state_t r;
    r = '0;
    r.bor = 1'b1;
    r.eval_busy = 1'b1;
    r.zcfg.upper_threshold = `ADCRZ_THRESH_RST;
    return r;
  endfunction

  localparam adcrz_state_t ST_RESET = reset_state();

  function automatic adcrz_mode_t mode_of(input logic [1:0] cm, input logic [1:0] sm);
    if (cm == `ADCRZ_CM_MANUAL && sm == `ADCRZ_SM_MANUAL) begin
      return M_MANUAL;
    end else if (cm == `ADCRZ_CM_MANUAL && sm == `ADCRZ_SM_SEQ) begin
      return M_AUTO;
    end else if (cm == `ADCRZ_CM_AUTON && sm == `ADCRZ_SM_SEQ) begin
      return M_AUTON;
    end
    return M_NONE;
  endfunction

  // next enabled channel above cur, wrapping
  function automatic logic [2:0] next_ch(input logic [7:0] mask, input logic [2:0] cur);
    logic [2:0] c;
    logic [2:0] r;
    logic hit;
    r = cur;
    hit = 1'b0;
    for (int k = 1; k <= 8; k++) begin
      c = 3'(int'(cur) + k);
      if (!hit && mask[c]) begin
        r = c;
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  logic scl, sda, scl_rise, scl_fall, start_c, stop_c, trig, wr_hit;
  logic [7:0] byte_in;
  logic [15:0] trial;
  logic [23:0] sq;
  logic [40:0] sumsq_n, mean;
  logic [4:0] shift;
  adcrz_mode_t mode;
  adcrz_gcfg_t wg;

  always_comb begin
    next_s = s;
    scl = s.scl_sy[1];
    sda = s.sda_sy[1];
    scl_rise = scl && !s.scl_d;
    scl_fall = !scl && s.scl_d;
    start_c = scl && s.scl_d && !sda && s.sda_d;
    stop_c = scl && s.scl_d && sda && !s.sda_d;
    byte_in = s.shreg;
    trig = 1'b0;
    trial = '0;
    sq = '0;
    sumsq_n = '0;
    mean = '0;
    shift = '0;
    wg = '0;
    wr_hit = avs_write_i && s.srv;
    mode = mode_of(s.gcfg.conversion_mode, s.gcfg.sequence_mode_field);
    next_s.scl_sy = {s.scl_sy[0], scl_i};
    next_s.sda_sy = {s.sda_sy[0], sda_i};
    next_s.scl_d = scl;
    next_s.sda_d = sda;
    next_s.addr_sy1 = addr_pin_i;
    next_s.addr_sy2 = s.addr_sy1;
    next_s.conv_go = 1'b0;
    next_s.soft_rst = 1'b0;
    // address evaluation from the strap
    if (s.eval_busy) begin
      next_s.eval_cnt = s.eval_cnt + 4'h1;
      if (s.eval_cnt == 4'(`ADCRZ_EVAL_CYC)) begin
        next_s.eval_busy = 1'b0;
        next_s.dev_addr = `ADCRZ_ADDR_BASE | {4'h0, s.addr_sy2};
      end
    end
    // serial link receiver
    if (start_c) begin
      next_s.i2c = I_ADDR;
      next_s.bitn = '0;
      next_s.gc = 1'b0;
      next_s.sda_low = 1'b0;
    end else if (stop_c) begin
      next_s.i2c = I_IDLE;
      next_s.hs = 1'b0;
      next_s.sda_low = 1'b0;
    end else begin
      case (s.i2c)
        I_ADDR, I_WR: begin
          if (scl_rise) begin
            next_s.shreg = {s.shreg[6:0], sda};
            next_s.bitn = s.bitn + 4'h1;
          end else if (scl_fall && s.bitn == `ADCRZ_BIT_LAST) begin
            next_s.i2c = (s.i2c == I_ADDR) ? I_AACK : I_WACK;
            next_s.sda_low = 1'b1;
            if (s.i2c == I_ADDR) begin
              next_s.rd = byte_in[0];
              if (byte_in == `ADCRZ_GC_ADDR) begin
                next_s.gc = 1'b1;
              end else if ((byte_in & `ADCRZ_HS_MASK) == `ADCRZ_HS_CODE) begin
                next_s.hs = 1'b1;
                next_s.i2c = I_IDLE;
                next_s.sda_low = 1'b0;
              end else if (byte_in[7:1] != s.dev_addr || s.eval_busy) begin
                next_s.i2c = I_IDLE;
                next_s.sda_low = 1'b0;
              end
            end else if (s.gc && byte_in == `ADCRZ_GC_RESET) begin
              next_s.soft_rst = 1'b1;
            end else if (s.gc && byte_in == `ADCRZ_GC_REEVAL) begin
              next_s.eval_busy = 1'b1;
              next_s.eval_cnt = '0;
            end
          end
        end
        I_AACK, I_WACK: begin
          if (scl_fall) begin
            next_s.bitn = '0;
            next_s.sda_low = 1'b0;
            next_s.i2c = I_WR;
            if (s.i2c == I_AACK && s.rd && !s.gc) begin
              next_s.i2c = I_RD;
              next_s.txsel = 1'b0;
              next_s.txb = s.last_data[11:4];
              next_s.sda_low = !s.last_data[11];
            end
          end
        end
        I_RD: begin
          if (scl_fall) begin
            next_s.bitn = s.bitn + 4'h1;
            next_s.txb = {s.txb[6:0], 1'b0};
            next_s.sda_low = !s.txb[6];
            if (s.bitn == `ADCRZ_BIT_LAST - 4'h1) begin
              next_s.i2c = I_RACK;
              next_s.sda_low = 1'b0;
            end
          end
        end
        I_RACK: begin
          if (scl_rise) begin
            next_s.rd = !sda;
          end else if (scl_fall) begin
            trig = s.txsel;
            next_s.txsel = !s.txsel;
            next_s.bitn = '0;
            next_s.i2c = I_IDLE;
            if (s.rd) begin
              next_s.i2c = I_RD;
              next_s.txb = s.txsel ? s.last_data[11:4] : {s.last_data[3:0], 4'h0};
              next_s.sda_low = s.txsel ? !s.last_data[11] : !s.last_data[3];
            end
          end
        end
        I_IDLE: begin
          next_s.sda_low = 1'b0;
        end
        default: begin
          next_s.i2c = I_IDLE;
        end
      endcase
    end
    // conversion control
    if (mode == M_MANUAL && !s.busy) begin
      next_s.conv_ch = s.chan.manual_channel_select;
    end
    if (mode == M_AUTON && s.gcfg.sequencer_run) begin
      if (trig) begin
        next_s.auton_run = 1'b1;
      end
      if (s.auton_run) begin
        next_s.tmr = s.tmr + 12'h1;
        if (s.tmr == 12'(`ADCRZ_AUTON_CYC - 1)) begin
          next_s.tmr = '0;
          trig = 1'b1;
        end
      end
    end else begin
      next_s.auton_run = 1'b0;
      next_s.tmr = '0;
    end
    if (trig && !s.busy && (mode == M_MANUAL || s.gcfg.sequencer_run) && mode != M_NONE) begin
      next_s.conv_go = 1'b1;
      next_s.busy = 1'b1;
    end
    if (conv_done_i) begin
      next_s.busy = 1'b0;
      next_s.last_data = conv_i.data;
      if (mode != M_MANUAL && s.gcfg.sequencer_run) begin
        next_s.conv_ch = next_ch(s.chan.sequencer_channel_mask, s.conv_ch);
      end
      if (s.gcfg.statistics_record_enable) begin
        next_s.stat_lat[conv_i.ch] = conv_i.data;
        if (!s.stat_valid[conv_i.ch] || conv_i.data < s.stat_min[conv_i.ch]) begin
          next_s.stat_min[conv_i.ch] = conv_i.data;
        end
        if (!s.stat_valid[conv_i.ch] || conv_i.data > s.stat_max[conv_i.ch]) begin
          next_s.stat_max[conv_i.ch] = conv_i.data;
        end
        next_s.stat_valid[conv_i.ch] = 1'b1;
      end
      if (!s.zcfg.upper_threshold[0] || 1'b1) begin
        if (s.chan.crossing_source_channel == {1'b0, conv_i.ch}) begin
          if (s.blank_cnt != '0) begin
            next_s.blank_cnt = s.blank_cnt - 7'h1;
          end else if ((conv_i.data >= s.zcfg.upper_threshold) != s.zero_crossing_detector) begin
            next_s.zero_crossing_detector = !s.zero_crossing_detector;
            next_s.blank_cnt = s.zcfg.blanking_multiplier_enable ? s.zcfg.crossing_blanking_count : '0;
          end
        end
      end
    end
    for (int i = 0; i < 8; i++) begin
      logic [1:0] zv;
      zv = (i < 4) ? s.gpo.crossing_value_cfg_low_outputs[i % 4] : s.gpo.crossing_value_cfg_high_outputs[i % 4];
      if (s.gpo.output_crossing_update_enable[i]) begin
        case (zv)
          `ADCRZ_ZV_LOW: next_s.gpo_q[i] = 1'b0;
          `ADCRZ_ZV_HIGH: next_s.gpo_q[i] = 1'b1;
          `ADCRZ_ZV_ZCD: next_s.gpo_q[i] = s.zero_crossing_detector;
          default: next_s.gpo_q[i] = !s.zero_crossing_detector;
        endcase
      end
    end
    // rms engine
    sq = conv_i.data * conv_i.data;
    sumsq_n = s.sumsq + {17'h0, sq};
    shift = `ADCRZ_WIN_SHIFT_BASE + {2'h0, s.chan.rms_window_count, 1'b0};
    mean = sumsq_n >> shift;
    trial = s.root | (16'h1 << s.sq_i);
    case (s.rms_st)
      R_IDLE: begin
      end
      R_ACC: begin
        if (conv_done_i && s.chan.rms_source_channel == {1'b0, conv_i.ch}) begin
          next_s.sumsq = sumsq_n;
          next_s.nsamp = s.nsamp + 17'h1;
          if (s.nsamp + 17'h1 == 17'(17'h1 << shift)) begin
            next_s.rms_st = R_SQRT;
            next_s.rad = {mean[23:0], 8'h00};
            next_s.root = '0;
            next_s.sq_i = 4'hf;
            next_s.tail = '0;
          end
        end
      end
      R_SQRT: begin
        if ({16'h0, trial} * {16'h0, trial} <= s.rad) begin
          next_s.root = trial;
        end
        next_s.sq_i = s.sq_i - 4'h1;
        if (s.sq_i == 4'h0) begin
          next_s.rms_st = R_TAIL;
        end
      end
      R_TAIL: begin
        if (conv_done_i && s.chan.rms_source_channel == {1'b0, conv_i.ch}) begin
          next_s.tail = s.tail + 6'h1;
          if (s.tail + 6'h1 == `ADCRZ_RMS_TAIL) begin
            next_s.rms_st = R_IDLE;
            next_s.rms_res = s.root;
          end
        end
      end
      default: begin
        next_s.rms_st = R_IDLE;
      end
    endcase
    // bus slave, one wait state
    next_s.srv = (avs_read_i || avs_write_i) && !s.srv;
    if (next_s.srv) begin
      case (avs_address_i)
        `ADCRZ_REG_STATUS: next_s.rdata = {29'h0, s.hs, s.rms_complete_flag, s.bor};
        `ADCRZ_REG_GCFG: next_s.rdata = s.gcfg;
        `ADCRZ_REG_CHAN: next_s.rdata = s.chan;
        `ADCRZ_REG_ZCFG: next_s.rdata = s.zcfg;
        `ADCRZ_REG_GPO: next_s.rdata = s.gpo;
        `ADCRZ_REG_RMS: next_s.rdata = {16'h0, s.rms_res};
        `ADCRZ_REG_SSEL: next_s.rdata = {29'h0, s.stat_sel};
        `ADCRZ_REG_SMM: next_s.rdata = {4'h0, s.stat_max[s.stat_sel], 4'h0, s.stat_min[s.stat_sel]};
        `ADCRZ_REG_SLAT: next_s.rdata = {19'h0, s.zero_crossing_detector, s.stat_lat[s.stat_sel]};
        default: next_s.rdata = '0;
      endcase
    end
    if (wr_hit) begin
      case (avs_address_i)
        `ADCRZ_REG_STATUS: begin
          if (avs_writedata_i[0]) begin
            next_s.bor = 1'b0;
          end
          if (avs_writedata_i[1]) begin
            next_s.rms_complete_flag = 1'b0;
          end
        end
        `ADCRZ_REG_GCFG: begin
          wg = avs_writedata_i;
          wg.rsv = '0;
          wg.rms_run_enable = 1'b0;
          wg.soft_reset = 1'b0;
          next_s.gcfg = wg;
          if (avs_writedata_i[0]) begin
            next_s.rms_st = R_ACC;
            next_s.sumsq = '0;
            next_s.nsamp = '0;
            next_s.rms_complete_flag = 1'b0;
          end
          if (wg.statistics_record_enable) begin
            next_s.stat_valid = '0;
          end
          if (avs_writedata_i[2]) begin
            next_s.soft_rst = 1'b1;
          end
        end
        `ADCRZ_REG_CHAN: next_s.chan = avs_writedata_i & 32'h00ff3ff7;
        `ADCRZ_REG_ZCFG: next_s.zcfg = avs_writedata_i & 32'h01ff0fff;
        `ADCRZ_REG_GPO: next_s.gpo = avs_writedata_i & 32'h00ffffff;
        `ADCRZ_REG_SSEL: next_s.stat_sel = avs_writedata_i[2:0];
        default: begin
        end
      endcase
    end
    // set wins over a status clear in the same cycle; a run-enable write in that cycle restarts and keeps it clear
    if (s.rms_st == R_TAIL && next_s.rms_st == R_IDLE) begin
      next_s.rms_complete_flag = 1'b1;
    end
    if (s.soft_rst) begin
      next_s = ST_RESET;
      next_s.scl_sy = s.scl_sy;
      next_s.sda_sy = s.sda_sy;
      next_s.scl_d = s.scl_d;
      next_s.sda_d = s.sda_d;
      next_s.addr_sy1 = s.addr_sy1;
      next_s.addr_sy2 = s.addr_sy2;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s <= ST_RESET;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign avs_readdata_o = s.rdata;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !s.srv;
  assign sda_o = 1'b0;
  assign sda_oe_o = s.sda_low;
  assign conv_start_o = s.conv_go;
  assign conv_channel_o = s.conv_ch;
  assign alert_o = s.rms_complete_flag && s.zcfg.rms_alert_mapping;
  assign gpo_o = s.gpo_q;
  assign dev_addr_o = s.dev_addr;
  assign high_speed_o = s.hs;
endmodule // adcrz_control
`default_nettype wire

// >>> verif/adcrz_control_props.sv
// checker on the control block's ports
// assumes it is bound into adcrz_control with ce_i held high
`timescale 1ns/100ps
`default_nettype none
module adcrz_control_props (
  input wire logic clk_i, // clock
  input wire logic reset_i, // reset
  input wire logic avs_read_i, // read
  input wire logic avs_write_i, // write
  input wire logic avs_waitrequest_o, // stall
  input wire logic scl_i, // link clock
  input wire logic sda_i, // link data
  input wire logic sda_oe_o, // data pull
  input wire logic [2:0] addr_pin_i, // strap
  input wire logic conv_start_o, // start
  input wire logic [7:0] gpo_o, // outputs
  input wire logic alert_o, // alert
  input wire logic [6:0] dev_addr_o, // address
  input wire logic high_speed_o // fast mode
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  property p_wait;
    $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer not after one wait");
  property p_stall;
    avs_waitrequest_o |-> avs_read_i || avs_write_i;
  endproperty
  a_stall: assert property (p_stall) else $error("stall without request");
  property p_addr;
    $fell(reset_i) |-> ##[1:20] dev_addr_o == (7'h10 | addr_pin_i);
  endproperty
  a_addr: assert property (p_addr) else $error("address not taken from strap");
  property p_ack;
    $rose(sda_oe_o) |-> !scl_i && !$past(scl_i);
  endproperty
  a_ack: assert property (p_ack) else $error("data pulled while link clock high");
  property p_start;
    $rose(conv_start_o) |-> !scl_i ##1 !conv_start_o;
  endproperty
  a_start: assert property (p_start) else $error("start not on link clock low");
  property p_rst;
    disable iff (1'b0) reset_i |=> gpo_o == 8'h00 && !alert_o && !high_speed_o && !conv_start_o && !sda_oe_o;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_manual;
    $fell(reset_i) |-> !conv_start_o [*8];
  endproperty
  a_manual: assert property (p_manual) else $error("conversion without host after reset");
  property p_hs;
    $fell(high_speed_o) |-> scl_i && sda_i;
  endproperty
  a_hs: assert property (p_hs) else $error("fast mode left without stop");
endmodule // adcrz_control_props
bind adcrz_control adcrz_control_props i_adcrz_control_props (.clk_i, .reset_i, .avs_read_i, .avs_write_i,
  .avs_waitrequest_o, .scl_i, .sda_i, .sda_oe_o, .addr_pin_i, .conv_start_o, .gpo_o, .alert_o, .dev_addr_o,
  .high_speed_o);
`default_nettype wire

// >>> verif/adcrz_i2c_host.sv
// host side of the two-wire link: start, stop and byte transfers
// assumes a pulled-up data line fed back on sda_i; half link period is four clocks
`timescale 1ns/100ps
`default_nettype none
module adcrz_i2c_host (
  input wire logic clk_i, // bench clock
  input wire logic sda_i, // resolved data line
  output logic scl_o, // link clock, still when idle
  output logic sda_low_o // high while pulling data low
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tick();
    repeat (4) @(posedge clk_i);
  endtask
  task automatic bit_io(input logic v, output logic r);
    sda_low_o <= !v;
    tick();
    scl_o <= 1'b1;
    tick();
    r = sda_i;
    scl_o <= 1'b0;
  endtask
  task automatic start();
    @(posedge clk_i);
    sda_low_o <= 1'b0;
    tick();
    scl_o <= 1'b1;
    tick();
    sda_low_o <= 1'b1;
    tick();
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    sda_low_o <= 1'b1;
    tick();
    scl_o <= 1'b1;
    tick();
    sda_low_o <= 1'b0;
    tick();
  endtask
  // last: 1 releases the ninth bit, 0 acknowledges it
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(last, r);
    ack = !r;
  endtask
endmodule // adcrz_i2c_host
`default_nettype wire

// >>> verif/tb_top.sv
// bench: register bus master, link frames through the host model, conversion responder
// assumes the host model and the checker are compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "adcrz_map.svh"
module tb_top import adcrz_pkg::*; ;
  logic clk_i, reset_i, ce_i, avs_read_i, avs_write_i, conv_done_i, avs_waitrequest_o, sda_o, sda_oe_o;
  logic conv_start_o, alert_o, high_speed_o, scl, m_low, ack, nk;
  logic [2:0] addr_pin_i, conv_channel_o, lastch, c1;
  logic [3:0] avs_address_i;
  logic [6:0] dev_addr_o;
  logic [7:0] gpo_o, b;
  logic [11:0] samp;
  logic [11:0] smp [3] = '{12'h123, 12'h456, 12'h0ab};
  logic [15:0] d;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  adcrz_conv_t conv_i;
  int error_cnt = 0;
  int checks_done = 0;
  int starts = 0;
  wire sda_w = !(m_low || (sda_oe_o && !sda_o));
  adcrz_control i_adcrz_control (.clk_i, .reset_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .scl_i(scl), .sda_i(sda_w), .sda_o, .sda_oe_o,
    .addr_pin_i, .conv_start_o, .conv_channel_o, .conv_done_i, .conv_i, .alert_o, .gpo_o, .dev_addr_o,
    .high_speed_o);
  adcrz_i2c_host i_adcrz_i2c_host (.clk_i, .sda_i(sda_w), .scl_o(scl), .sda_low_o(m_low));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // converter stand-in: answers each start one cycle later
  always @(posedge clk_i) begin
    conv_done_i <= conv_start_o;
    conv_i <= {conv_channel_o, samp};
    if (conv_start_o === 1'b1) begin
      starts <= starts + 1;
      lastch <= conv_channel_o;
    end
  end
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 50) begin
      error_cnt++;
      summarize();
    end
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic rd_frame(input logic [6:0] a);
    i_adcrz_i2c_host.start();
    i_adcrz_i2c_host.xfer({a, 1'b1}, 1'b1, b, ack);
    d = 16'h0;
    if (ack === 1'b1) begin
      i_adcrz_i2c_host.xfer(8'hff, 1'b0, d[15:8], nk);
      i_adcrz_i2c_host.xfer(8'hff, 1'b1, d[7:0], nk);
    end
    i_adcrz_i2c_host.stop();
    repeat (4) @(posedge clk_i);
  endtask
  task automatic gc(input logic [7:0] cmd);
    i_adcrz_i2c_host.start();
    i_adcrz_i2c_host.xfer(`ADCRZ_GC_ADDR, 1'b1, b, ack);
    chk(ack, 1);
    i_adcrz_i2c_host.xfer(cmd, 1'b1, b, ack);
    i_adcrz_i2c_host.stop();
    repeat (20) @(posedge clk_i);
  endtask
  initial begin
    reset_i = 1'b1;
    ce_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 4'h0;
    avs_writedata_i = 32'h0;
    conv_done_i = 1'b0;
    conv_i = '0;
    addr_pin_i = 3'h5;
    samp = 12'h123;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk(dev_addr_o, 32'h15);
    bus(0, `ADCRZ_REG_STATUS, 0);
    chk(q, 32'h1);
    bus(0, `ADCRZ_REG_GCFG, 0);
    chk(q, 32'h0);
    bus(0, `ADCRZ_REG_ZCFG, 0);
    chk(q[11:0], `ADCRZ_THRESH_RST);
    bus(0, 4'hf, 0);
    chk(q, 32'h0);
    bus(1, `ADCRZ_REG_CHAN, 32'h33);
    bus(1, `ADCRZ_REG_ZCFG, 32'h0081_0200);
    bus(1, `ADCRZ_REG_GPO, 32'h1e07);
    bus(1, `ADCRZ_REG_GCFG, 32'h2);
    for (int i = 0; i < 3; i++) begin
      samp = smp[i];
      rd_frame(7'h15);
      chk(d, i == 0 ? 32'h0 : {smp[i - 1], 4'h0});
      chk(starts, i + 1);
      chk(lastch, 3);
      chk(gpo_o[2:0], {1'b1, i == 0, i > 0});
    end
    bus(1, `ADCRZ_REG_GCFG, 0);
    bus(1, `ADCRZ_REG_SSEL, 3);
    bus(0, `ADCRZ_REG_SMM, 0);
    chk(q, 32'h0456_00ab);
    bus(0, `ADCRZ_REG_SLAT, 0);
    chk(q, 32'h0000_10ab);
    bus(1, `ADCRZ_REG_GCFG, 32'h2);
    bus(0, `ADCRZ_REG_SMM, 0);
    chk(q, 32'h0456_00ab);
    samp = 12'h300;
    rd_frame(7'h15);
    bus(1, `ADCRZ_REG_GCFG, 0);
    bus(0, `ADCRZ_REG_SMM, 0);
    chk(q, 32'h0300_0300);
    for (int c = 9; c < 16; c += 2) begin
      i_adcrz_i2c_host.start();
      i_adcrz_i2c_host.xfer(8'(c), 1'b1, b, ack);
      chk(ack, 0);
      chk(high_speed_o, 1);
      bus(0, `ADCRZ_REG_STATUS, 0);
      chk(q[2], 1);
      i_adcrz_i2c_host.stop();
      repeat (8) @(posedge clk_i);
      chk(high_speed_o, 0);
    end
    rd_frame(7'h16);
    chk(ack, 0);
    bus(1, `ADCRZ_REG_CHAN, 32'h000a_0000);
    bus(1, `ADCRZ_REG_GCFG, 32'h48);
    rd_frame(7'h15);
    rd_frame(7'h15);
    c1 = lastch;
    rd_frame(7'h15);
    chk(c1 ^ lastch, 2);
    @(posedge clk_i);
    addr_pin_i <= 3'h2;
    gc(`ADCRZ_GC_REEVAL);
    chk(dev_addr_o, 32'h12);
    bus(1, `ADCRZ_REG_STATUS, 1);
    bus(0, `ADCRZ_REG_STATUS, 0);
    chk(q[0], 0);
    bus(1, `ADCRZ_REG_GCFG, 32'h2);
    gc(`ADCRZ_GC_RESET);
    bus(0, `ADCRZ_REG_GCFG, 0);
    chk(q, 0);
    bus(0, `ADCRZ_REG_STATUS, 0);
    chk(q[0], 1);
    bus(1, `ADCRZ_REG_STATUS, 1);
    bus(1, `ADCRZ_REG_ZCFG, 32'h0100_0100);
    bus(1, `ADCRZ_REG_GCFG, 32'h4);
    chk(alert_o, 0);
    repeat (20) @(posedge clk_i);
    bus(0, `ADCRZ_REG_STATUS, 0);
    chk(q[0], 1);
    bus(0, `ADCRZ_REG_ZCFG, 0);
    chk(q[11:0], `ADCRZ_THRESH_RST);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
